// [rtl/flash_partition_memory_decoder.sv]
/*
 * Flash partition memory decoder: routes core accesses to flash, SRAM or the external bus.
 * Assumes the core holds one request per cycle and that flash and SRAM accept each routed access.
 */
// The register offsets and strobed register access were decided locally.
//
// Functional notes
// R1 - Reads of undefined special function register addresses return zero.
// R2 - Flash pages are 128 bytes; a page must be erased before writing.
// R3 - Program and data spaces are separate 64 kB spaces that may overlap.
// R4 - Fetches and code reads use program space; data moves use data space.
// R5 - On-chip range goes internal; beyond it goes to the external bus.
// R6 - Configuration bytes change only in flash programming mode.
// R7 - Code 111 puts all flash in program region, none in data region.
// R8 - Code 110 gives 1 kB to data region.
// R9 - Code 101 gives 2 kB to data region.
// R10 - Code 100 gives 4 kB to data region; a 4 kB part has no program region.
// R11 - Code 011 gives 8 kB to data region, capped at flash size.
// R12 - Code 010 gives 16 kB to data region, capped at flash size.
// R13 - Codes 000 and 001 give all flash to data region.
// R14 - With no program region, all fetches go external; the code still sends fetches that hit relocated SRAM at 8400h to SRAM.
// R15 - Instructions are never fetched from data region flash.
// R16 - Lock blocks user-mode erase and write of low 4 kB or all program flash.
// R17 - Unlocked program and data flash accept erase and write in user mode.
// R18 - SRAM sits at data 0, or relocated at 8400h for both spaces.
// R19 - Data region flash sits directly above SRAM in data space.
// R20 - Program region shrinks from the top; fetches above it go external; the code still sends fetches that hit relocated SRAM to SRAM.
// R21 - Secondary byte sits at 807Eh, partition byte at 807Fh.
// R22 - Boundary comes from the code and flash size, capped at flash size.
`timescale 1ns/1ps

module flash_partition_memory_decoder #(
    parameter logic [16:0] FLASH_KB = flash_map_pkg::FLASH_KB_DEF
) (
    input  wire logic                       CLK_SYS,
    input  wire logic                       RESETN,
    input  wire logic                       PROG_MODE,
    input  wire flash_map_pkg::request_type REQ,
    input  wire logic [7:0]                 SFR_ADDR,
    input  wire logic                       SFR_RD,
    output logic [7:0]                      SFR_RDATA,
    output flash_map_pkg::route_type        ROUTE,
    output logic [7:0]                      PARTITION_CFG,
    output logic [7:0]                      SECONDARY_CFG,
    output logic [15:0]                     PROG_TOP,
    output logic [15:0]                     DATA_TOP
);

    // ------------------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------------------
    logic [2:0] mode_sync_q;
    logic       prog_mode_q;

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mode_sync_q <= 3'h0;
        end
        else
        begin
            mode_sync_q <= {mode_sync_q[1:0], PROG_MODE};
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            prog_mode_q <= 1'b0;
        end
        else if (mode_sync_q[1] == mode_sync_q[2])
        begin
            prog_mode_q <= mode_sync_q[2];
        end
    end

    // ------------------------------------------------------------------------
    // Configuration bytes
    // ------------------------------------------------------------------------
    logic [7:0] partition_q;
    logic [7:0] secondary_q;
    logic       cfg_wr;

    assign cfg_wr = REQ.valid && prog_mode_q && REQ.kind == flash_map_pkg::KIND_DATA_MOVE
                    && REQ.op == flash_map_pkg::OP_WRITE;

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            partition_q <= flash_map_pkg::PARTITION_RST;
            secondary_q <= flash_map_pkg::SECONDARY_RST;
        end
        else if (cfg_wr) // [R6]
        begin
            if (REQ.addr == flash_map_pkg::PARTITION_ADR) // [R21]
            begin
                partition_q <= REQ.wdata;
            end
            if (REQ.addr == flash_map_pkg::SECONDARY_ADR) // [R21]
            begin
                secondary_q <= REQ.wdata;
            end
        end
    end

    assign PARTITION_CFG = partition_q;
    assign SECONDARY_CFG = secondary_q;

    // ------------------------------------------------------------------------
    // Partition boundary
    // ------------------------------------------------------------------------
    logic [2:0]  dfs;
    logic [16:0] data_kb;
    logic [16:0] prog_kb;
    logic [16:0] prog_bytes;
    logic [16:0] data_bytes;
    logic [16:0] flash_bytes;
    logic [16:0] data_base;
    logic [16:0] data_end;

    assign dfs = partition_q[flash_map_pkg::DFS_LSB +: 3];

    always_comb
    begin
        unique case (dfs)
            flash_map_pkg::DFS_NONE: data_kb = flash_map_pkg::KB_0;      // [R7]
            flash_map_pkg::DFS_1K:   data_kb = flash_map_pkg::KB_1;      // [R8]
            flash_map_pkg::DFS_2K:   data_kb = flash_map_pkg::KB_2;      // [R9]
            flash_map_pkg::DFS_4K:   data_kb = flash_map_pkg::KB_4;      // [R10]
            flash_map_pkg::DFS_8K:   data_kb = flash_map_pkg::KB_8;      // [R11]
            flash_map_pkg::DFS_16K:  data_kb = flash_map_pkg::KB_16;     // [R12]
            default:                 data_kb = FLASH_KB;                 // [R13]
        endcase
        if (data_kb > FLASH_KB) // [R22]
        begin
            data_kb = FLASH_KB;
        end
    end

    assign prog_kb     = FLASH_KB - data_kb;
    assign prog_bytes  = prog_kb << flash_map_pkg::KB_SHIFT;
    assign data_bytes  = data_kb << flash_map_pkg::KB_SHIFT;
    assign flash_bytes = FLASH_KB << flash_map_pkg::KB_SHIFT;
    assign data_base   = {1'b0, flash_map_pkg::SRAM_BYTES};
    assign data_end    = data_base + data_bytes; // [R19]

    assign PROG_TOP = prog_bytes[15:0];
    assign DATA_TOP = data_end[15:0];

    // ------------------------------------------------------------------------
    // Page erase tracking
    // ------------------------------------------------------------------------
    localparam int NPAGES = 1 << flash_map_pkg::PAGE_W;

    logic [NPAGES-1:0] erased_q;
    logic [16:0]       flash_off;
    logic [flash_map_pkg::PAGE_W-1:0] page_idx;

    assign page_idx = flash_off[flash_map_pkg::PAGE_SHIFT +: flash_map_pkg::PAGE_W];

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    logic                      reloc;
    logic [16:0]               a17;
    logic                      in_reloc;
    logic                      locked;
    flash_map_pkg::target_type tgt;
    logic                      fault;
    logic                      is_prog_flash;

    assign reloc    = secondary_q[flash_map_pkg::RELOC_BIT];
    assign a17      = {1'b0, REQ.addr};
    assign in_reloc = reloc && REQ.addr >= flash_map_pkg::SRAM_RELOC
                      && a17 < {1'b0, flash_map_pkg::SRAM_RELOC} + data_base;

    always_comb
    begin
        tgt           = flash_map_pkg::TGT_EXTERNAL;
        flash_off     = 17'h0_0000;
        is_prog_flash = 1'b0;
        unique case (REQ.kind)
            flash_map_pkg::KIND_FETCH, flash_map_pkg::KIND_CODE_READ: // [R4]
            begin
                if (in_reloc) // [R18]
                begin
                    tgt = flash_map_pkg::TGT_SRAM;
                end
                else if (a17 < prog_bytes) // [R15] [R20] [R14]
                begin
                    tgt           = flash_map_pkg::TGT_FLASH;
                    flash_off     = a17;
                    is_prog_flash = 1'b1;
                end
            end
            default:
            begin
                if (in_reloc || (!reloc && a17 < data_base)) // [R18]
                begin
                    tgt = flash_map_pkg::TGT_SRAM;
                end
                else if (a17 >= data_base && a17 < data_end) // [R19] [R3]
                begin
                    tgt       = flash_map_pkg::TGT_FLASH;
                    flash_off = a17 - data_base + prog_bytes;
                end
            end
        endcase
    end

    assign locked = !prog_mode_q && partition_q[flash_map_pkg::LOCK_EN_BIT] && is_prog_flash
                    && (partition_q[flash_map_pkg::LOCK_ALL_BIT]
                        || REQ.addr < flash_map_pkg::LOCK_LOW_END); // [R16]

    always_comb
    begin
        fault = 1'b0;
        if (tgt == flash_map_pkg::TGT_FLASH && REQ.op != flash_map_pkg::OP_READ)
        begin
            if (REQ.kind == flash_map_pkg::KIND_FETCH || locked) // [R16] [R17]
            begin
                fault = 1'b1;
            end
            else if (REQ.op == flash_map_pkg::OP_WRITE && !erased_q[page_idx]) // [R2]
            begin
                fault = 1'b1;
            end
        end
        if (flash_off >= flash_bytes && tgt == flash_map_pkg::TGT_FLASH)
        begin
            fault = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            erased_q <= '0;
        end
        else if (REQ.valid && tgt == flash_map_pkg::TGT_FLASH && !fault)
        begin
            if (REQ.op == flash_map_pkg::OP_ERASE) // [R2]
            begin
                erased_q[page_idx] <= 1'b1;
            end
            else if (REQ.op == flash_map_pkg::OP_WRITE)
            begin
                erased_q[page_idx] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Routed output and register read port
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ROUTE <= '0;
        end
        else
        begin
            ROUTE.valid  <= REQ.valid;
            ROUTE.target <= fault ? flash_map_pkg::TGT_NONE : tgt; // [R5]
            ROUTE.addr   <= (tgt == flash_map_pkg::TGT_FLASH) ? flash_off[15:0] : REQ.addr;
            ROUTE.write  <= REQ.op == flash_map_pkg::OP_WRITE;
            ROUTE.erase  <= REQ.op == flash_map_pkg::OP_ERASE;
            ROUTE.wdata  <= REQ.wdata;
            ROUTE.fault  <= REQ.valid && fault;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            SFR_RDATA <= 8'h00;
        end
        else if (SFR_RD)
        begin
            SFR_RDATA <= 8'h00; // [R1]
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_cfg_hold;
        @(posedge CLK_SYS) disable iff (!RESETN)
        !prog_mode_q |=> $stable(partition_q) && $stable(secondary_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed in user mode"); // [R6]

    property p_sfr_zero;
        @(posedge CLK_SYS) disable iff (!RESETN)
        SFR_RD |=> SFR_RDATA == 8'h00;
    endproperty
    a_sfr_zero: assert property (p_sfr_zero) else $error("undefined register not zero"); // [R1]

    property p_fetch_data;
        @(posedge CLK_SYS) disable iff (!RESETN)
        REQ.valid && REQ.kind == flash_map_pkg::KIND_FETCH && a17 >= prog_bytes && !in_reloc
        |=> ROUTE.target != flash_map_pkg::TGT_FLASH;
    endproperty
    a_fetch_data: assert property (p_fetch_data) else $error("fetch from data flash"); // [R15]

    property p_write_unerased;
        @(posedge CLK_SYS) disable iff (!RESETN)
        REQ.valid && tgt == flash_map_pkg::TGT_FLASH && REQ.op == flash_map_pkg::OP_WRITE
        && !erased_q[page_idx] |=> ROUTE.fault;
    endproperty
    a_write_unerased: assert property (p_write_unerased) else $error("unerased write"); // [R2]

    property p_lock;
        @(posedge CLK_SYS) disable iff (!RESETN)
        REQ.valid && locked && REQ.op != flash_map_pkg::OP_READ |=> ROUTE.fault;
    endproperty
    a_lock: assert property (p_lock) else $error("locked flash modified"); // [R16]

    property p_default_all_prog;
        @(posedge CLK_SYS) disable iff (!RESETN)
        dfs == flash_map_pkg::DFS_NONE |-> prog_kb == FLASH_KB && data_end == data_base;
    endproperty
    a_default_all_prog: assert property (p_default_all_prog) else $error("bad 111 split"); // [R7]

    property p_all_data;
        @(posedge CLK_SYS) disable iff (!RESETN)
        dfs[2:1] == 2'h0 |-> prog_kb == flash_map_pkg::KB_0;
    endproperty
    a_all_data: assert property (p_all_data) else $error("bad all-data split"); // [R13]

    property p_sram_low;
        @(posedge CLK_SYS) disable iff (!RESETN)
        REQ.valid && !reloc && REQ.kind == flash_map_pkg::KIND_DATA_MOVE && a17 < data_base
        |=> ROUTE.target == flash_map_pkg::TGT_SRAM && ROUTE.valid;
    endproperty
    a_sram_low: assert property (p_sram_low) else $error("low data not in sram"); // [R18]

    property p_external;
        @(posedge CLK_SYS) disable iff (!RESETN)
        REQ.valid && REQ.kind != flash_map_pkg::KIND_DATA_MOVE && !in_reloc
        && a17 >= prog_bytes |=> ROUTE.target == flash_map_pkg::TGT_EXTERNAL;
    endproperty
    a_external: assert property (p_external) else $error("high program not external"); // [R20]

    sequence s_partition_write;
        cfg_wr && REQ.addr == flash_map_pkg::PARTITION_ADR;
    endsequence

    property p_cfg_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
        s_partition_write |=> partition_q == $past(REQ.wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("partition not written"); // [R6]

    property p_data_erase;
        @(posedge CLK_SYS) disable iff (!RESETN)
        REQ.valid && REQ.kind == flash_map_pkg::KIND_DATA_MOVE
        && REQ.op == flash_map_pkg::OP_ERASE && tgt == flash_map_pkg::TGT_FLASH
        |=> ROUTE.erase && !ROUTE.fault;
    endproperty
    a_data_erase: assert property (p_data_erase) else $error("data erase refused"); // [R17]

    // An accepted erase, an idle cycle, then a write into the same page must be accepted.
    sequence s_erase_taken;
        REQ.valid && REQ.op == flash_map_pkg::OP_ERASE
        && tgt == flash_map_pkg::TGT_FLASH && !fault;
    endsequence

    sequence s_write_same_page;
        REQ.valid && REQ.op == flash_map_pkg::OP_WRITE && tgt == flash_map_pkg::TGT_FLASH
        && REQ.kind != flash_map_pkg::KIND_FETCH && !locked && page_idx == $past(page_idx, 2);
    endsequence

    property p_erase_write;
        @(posedge CLK_SYS) disable iff (!RESETN)
        s_erase_taken ##1 !REQ.valid ##1 s_write_same_page |=> !ROUTE.fault;
    endproperty
    a_erase_write: assert property (p_erase_write) else $error("erased page refused"); // [R2]

endmodule

// [include/flash_map_pkg.sv]
/*
 * Constants and carrier types for the flash partition memory decoder.
 * Assumes a 16-bit program space and a 16-bit data space reached by separate access kinds.
 */
package flash_map_pkg;

    // ------------------------------------------------------------------------
    // Address spaces and sizes
    // ------------------------------------------------------------------------
    localparam int          ADDR_W        = 16;
    localparam int          PAGE_BYTES    = 128;
    localparam int          PAGE_SHIFT    = 7;
    localparam int          KB_SHIFT      = 10;
    localparam logic [16:0] FLASH_KB_DEF  = 17'h0_0020;
    localparam logic [15:0] SRAM_BYTES    = 16'h0400;
    localparam logic [15:0] SRAM_RELOC    = 16'h8400;
    localparam logic [15:0] LOCK_LOW_END  = 16'h1000;
    localparam logic [15:0] SECONDARY_ADR = 16'h807E;
    localparam logic [15:0] PARTITION_ADR = 16'h807F;
    localparam int          PAGE_W        = 9;

    // ------------------------------------------------------------------------
    // Partition code field and lock field positions
    // ------------------------------------------------------------------------
    localparam int          DFS_LSB       = 0;
    localparam int          LOCK_EN_BIT   = 3;
    localparam int          LOCK_ALL_BIT  = 4;
    localparam int          RELOC_BIT     = 0;
    localparam logic [7:0]  PARTITION_RST = 8'hFF;
    localparam logic [7:0]  SECONDARY_RST = 8'hFF;

    localparam logic [2:0]  DFS_1K   = 3'h6;
    localparam logic [2:0]  DFS_2K   = 3'h5;
    localparam logic [2:0]  DFS_4K   = 3'h4;
    localparam logic [2:0]  DFS_8K   = 3'h3;
    localparam logic [2:0]  DFS_16K  = 3'h2;
    localparam logic [2:0]  DFS_NONE = 3'h7;

    localparam logic [16:0] KB_0  = 17'h0_0000;
    localparam logic [16:0] KB_1  = 17'h0_0001;
    localparam logic [16:0] KB_2  = 17'h0_0002;
    localparam logic [16:0] KB_4  = 17'h0_0004;
    localparam logic [16:0] KB_8  = 17'h0_0008;
    localparam logic [16:0] KB_16 = 17'h0_0010;

    typedef enum logic [1:0] {
        KIND_FETCH,
        KIND_CODE_READ,
        KIND_DATA_MOVE
    } access_kind_type;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_ERASE
    } access_op_type;

    typedef enum logic [1:0] {
        TGT_FLASH,
        TGT_SRAM,
        TGT_EXTERNAL,
        TGT_NONE
    } target_type;

    typedef struct packed {
        logic            valid;
        access_kind_type kind;
        access_op_type   op;
        logic [15:0]     addr;
        logic [7:0]      wdata;
    } request_type;

    typedef struct packed {
        logic        valid;
        target_type  target;
        logic [15:0] addr;
        logic        write;
        logic        erase;
        logic [7:0]  wdata;
        logic        fault;
    } route_type;

endpackage

// [test/core_model.sv]
/*
 * Processor core model that issues program fetches, code reads and data moves.
 * Assumes the decoder samples its request on every rising edge of the system clock.
 */
`timescale 1ns/1ps

module core_model (
    input  wire logic                  CLK_SYS,
    output flash_map_pkg::request_type REQ
);
    // ------------------------------------------------------------------------
    // Request issue
    // ------------------------------------------------------------------------
    initial REQ = '0;

    // The request is held for exactly one sampling edge, then withdrawn.
    task automatic issue(
        input flash_map_pkg::access_kind_type kind,
        input flash_map_pkg::access_op_type   op,
        input logic [15:0]                    addr,
        input logic [7:0]                     wdata
    );
        @(posedge CLK_SYS);
        REQ <= '{valid: 1'b1, kind: kind, op: op, addr: addr, wdata: wdata};
        @(posedge CLK_SYS);
        REQ.valid <= 1'b0;
    endtask
endmodule

// [test/flash_partition_memory_decoder_tb.sv]
/*
 * Self-checking bench for the flash partition memory decoder with a 32 kB part.
 * Assumes the core model drives requests and the bench drives mode and register reads.
 */
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        num_checks++; \
        if ((a) !== (e)) \
        begin \
            fails++; \
            $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
        end \
    end

module flash_partition_memory_decoder_tb;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    localparam flash_map_pkg::access_kind_type k_f = flash_map_pkg::KIND_FETCH;
    localparam flash_map_pkg::access_kind_type k_c = flash_map_pkg::KIND_CODE_READ;
    localparam flash_map_pkg::access_kind_type k_d = flash_map_pkg::KIND_DATA_MOVE;
    localparam flash_map_pkg::access_op_type   o_r = flash_map_pkg::OP_READ;
    localparam flash_map_pkg::access_op_type   o_w = flash_map_pkg::OP_WRITE;
    localparam flash_map_pkg::access_op_type   o_e = flash_map_pkg::OP_ERASE;
    localparam flash_map_pkg::target_type      t_f = flash_map_pkg::TGT_FLASH;
    localparam flash_map_pkg::target_type      t_s = flash_map_pkg::TGT_SRAM;
    localparam flash_map_pkg::target_type      t_x = flash_map_pkg::TGT_EXTERNAL;
    localparam flash_map_pkg::target_type      t_n = flash_map_pkg::TGT_NONE;

    logic                       clk_sys = 1'b0;
    logic                       resetn;
    logic                       prog_mode;
    logic [7:0]                 sfr_addr;
    logic                       sfr_rd;
    logic [7:0]                 sfr_rdata;
    logic [7:0]                 part_cfg;
    logic [7:0]                 sec_cfg;
    logic [15:0]                prog_top;
    logic [15:0]                data_top;
    flash_map_pkg::request_type req;
    flash_map_pkg::route_type   route;
    int                         fails = 0;
    int                         num_checks = 0;
    int                         cyc = 0;
    logic [15:0]                top_exp [8] = '{16'h0000, 16'h0000, 16'h4000, 16'h6000,
                                                16'h7000, 16'h7800, 16'h7C00, 16'h8000};
    logic [15:0]                dtop_exp [8] = '{16'h8400, 16'h8400, 16'h4400, 16'h2400,
                                                 16'h1400, 16'h0C00, 16'h0800, 16'h0400};

    always #12.5 clk_sys = ~clk_sys;

    core_model core (
        .CLK_SYS (clk_sys),
        .REQ     (req)
    );

    flash_partition_memory_decoder #(.FLASH_KB(17'h0_0020)) dut (
        .CLK_SYS       (clk_sys),
        .RESETN        (resetn),
        .PROG_MODE     (prog_mode),
        .REQ           (req),
        .SFR_ADDR      (sfr_addr),
        .SFR_RD        (sfr_rd),
        .SFR_RDATA     (sfr_rdata),
        .ROUTE         (route),
        .PARTITION_CFG (part_cfg),
        .SECONDARY_CFG (sec_cfg),
        .PROG_TOP      (prog_top),
        .DATA_TOP      (data_top)
    );

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Issues one access and judges the routed answer one cycle later.
    task automatic go(
        input flash_map_pkg::access_kind_type kind,
        input flash_map_pkg::access_op_type   op,
        input logic [15:0]                    a,
        input flash_map_pkg::target_type      tgt,
        input logic [15:0]                    ea,
        input logic                           flt
    );
        core.issue(kind, op, a, 8'h5A);
        #1;
        `CHK(route.valid, 1'b1)
        `CHK(route.target, tgt)
        `CHK(route.fault, flt)
        if (tgt != t_n)
            `CHK(route.addr, ea)
        if (tgt == t_f)
        begin
            `CHK(route.erase, op == o_e)
            `CHK(route.write, op == o_w)
            `CHK(route.wdata, 8'h5A)
        end
    endtask

    task automatic set_mode(input logic v);
        @(posedge clk_sys);
        prog_mode <= v;
        repeat (6) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset_and_sfr();
        logic [7:0] adr [3] = '{8'h80, 8'hC5, 8'hFF};
        `CHK(part_cfg, 8'hFF)
        `CHK(sec_cfg, 8'hFF)
        `CHK(prog_top, 16'h8000)
        foreach (adr[i])
        begin
            @(posedge clk_sys);
            sfr_addr <= adr[i];
            sfr_rd   <= 1'b1;
            @(posedge clk_sys);
            sfr_rd   <= 1'b0;
            #1;
            `CHK(sfr_rdata, 8'h00)
        end
    endtask

    task automatic t_default_map();
        go(k_f, o_r, 16'h0100, t_f, 16'h0100, 1'b0);
        go(k_f, o_r, 16'h8000, t_x, 16'h8000, 1'b0);
        go(k_c, o_r, 16'h8410, t_s, 16'h8410, 1'b0);
        go(k_d, o_r, 16'h8410, t_s, 16'h8410, 1'b0);
        go(k_c, o_e, 16'h4000, t_n, 16'h0000, 1'b1);
    endtask

    task automatic t_codes();
        set_mode(1'b1);
        for (int i = 0; i < 8; i++)
        begin
            core.issue(k_d, o_w, flash_map_pkg::PARTITION_ADR, 8'(i));
            #1;
            `CHK(part_cfg, 8'(i))
            `CHK(prog_top, top_exp[i])
            `CHK(data_top, dtop_exp[i])
            if (i == 0)
                go(k_f, o_r, 16'h0000, t_x, 16'h0000, 1'b0);
        end
        core.issue(k_d, o_w, flash_map_pkg::SECONDARY_ADR, 8'hFE);
        core.issue(k_d, o_w, flash_map_pkg::PARTITION_ADR, 8'h0E);
        #1;
        `CHK(sec_cfg, 8'hFE)
        `CHK(part_cfg, 8'h0E)
        set_mode(1'b0);
    endtask

    task automatic t_routing();
        go(k_d, o_r, 16'h0010, t_s, 16'h0010, 1'b0);
        go(k_d, o_r, 16'h07FF, t_f, 16'h7FFF, 1'b0);
        go(k_d, o_r, 16'h0800, t_x, 16'h0800, 1'b0);
        go(k_f, o_r, 16'h7BFF, t_f, 16'h7BFF, 1'b0);
        go(k_f, o_r, 16'h7C00, t_x, 16'h7C00, 1'b0);
        core.issue(k_d, o_w, flash_map_pkg::PARTITION_ADR, 8'h07);
        #1;
        `CHK(part_cfg, 8'h0E)
    endtask

    task automatic t_flash_ops();
        go(k_d, o_w, 16'h0500, t_n, 16'h0000, 1'b1);
        go(k_d, o_e, 16'h0500, t_f, 16'h7D00, 1'b0);
        go(k_d, o_w, 16'h057F, t_f, 16'h7D7F, 1'b0);
        go(k_d, o_w, 16'h0500, t_n, 16'h0000, 1'b1);
        go(k_f, o_w, 16'h0100, t_n, 16'h0000, 1'b1);
        go(k_c, o_e, 16'h0FFF, t_n, 16'h0000, 1'b1);
        go(k_c, o_e, 16'h1000, t_f, 16'h1000, 1'b0);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            $display("ERROR t=%0t timeout", $time);
            end_of_test();
        end
    end

    initial
    begin
        resetn    = 1'b0;
        prog_mode = 1'b0;
        sfr_addr  = 8'h00;
        sfr_rd    = 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        t_reset_and_sfr();
        t_default_map();
        t_codes();
        t_routing();
        t_flash_ops();
        end_of_test();
    end
endmodule
